//--- logic/scan_layer_trigger_sequencer.sv
// Purpose: Scan-layer sequencer: picks the pacing event, counts scans, hands over to the channel layer.
// Assumes: APB slave on the system clock; channel layer runs on the same clock.
// Notes:   Pins pass a two-flop synchroniser; zero-wait APB with registered read data.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
module scan_layer_trigger_sequencer
	import scan_seq_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	// Clock and reset
	input  wire logic                 I_CLK_SYS,
	input  wire logic                 I_ARST_N,
	// APB slave
	input  wire logic                 I_PSEL,
	input  wire logic                 I_PENABLE,
	input  wire logic                 I_PWRITE,
	input  wire logic [7:0]           I_PADDR,
	input  wire logic [31:0]          I_PWDATA,
	output wire logic [31:0]          O_PRDATA,
	output wire logic                 O_PREADY,
	output wire logic                 O_PSLVERR,
	// Trigger pins
	input  wire logic                 I_EXT_TRIG,
	input  wire logic                 I_STEP_KEY,
	input  wire logic [NUM_LINES-1:0] I_TLINE_IN,
	output wire logic [NUM_LINES-1:0] O_TLINE_OUT,
	output wire logic [NUM_LINES-1:0] O_TLINE_OE,
	// Channel layer
	input  wire logic                 I_CHAN_EVENT,
	input  wire logic                 I_SCAN_DONE,
	output wire logic                 O_SCAN_START,
	output wire logic                 O_CHAN_STEP,
	output wire logic                 O_SCAN_ACTIVE,
	// Arm layer
	output wire logic                 O_ARM_RETURN
);
	localparam int SYNC_W = NUM_LINES + 2;

	// Line number to one-hot mask; zero for numbers outside 1 to 6
	function automatic logic [NUM_LINES-1:0] line_onehot(input logic [LINE_W-1:0] num);
		logic [NUM_LINES-1:0] mask;
		mask = '0;
		for (int i = 0; i < NUM_LINES; i++) begin
			if (num == LINE_W'(i + 1)) begin
				mask[i] = 1'b1;
			end
		end
		return mask;
	endfunction

	// Write refused for unknown and read-only offsets, out-of-range values and equal in and out lines
	function automatic logic write_refused(input logic [7:0] addr, input logic [31:0] data);
		logic [LINE_W-1:0] in_l;
		logic [LINE_W-1:0] out_l;
		logic              bad;
		in_l  = data[LINES_IN_LSB +: LINE_W];
		out_l = data[LINES_OUT_LSB +: LINE_W];
		bad   = 1'b0;
		if (addr == ADDR_CTRL) begin
			bad = (data[CTRL_SRC_LSB +: 3] > 3'(SRC_HOLD));
		end else if (addr == ADDR_LINES) begin
			bad = (line_onehot(in_l) == '0) || (line_onehot(out_l) == '0) || (in_l == out_l);
		end else if (addr == ADDR_INTERVAL) begin
			bad = (data > 32'(INTERVAL_MAX_MS));
		end else if (addr == ADDR_COUNT) begin
			bad = (data > 32'(COUNT_MAX));
		end else if (addr == ADDR_CMD) begin
			bad = 1'b0;
		end else begin
			bad = 1'b1;
		end
		return bad;
	endfunction

	// Configuration and state
	source_type            source_reg;
	logic                  bypass_reg;
	logic [LINE_W-1:0]     in_line_reg;
	logic [LINE_W-1:0]     out_line_reg;
	logic [INTERVAL_W-1:0] interval_reg;
	logic [COUNT_W-1:0]    total_reg;
	logic [COUNT_W-1:0]    done_cnt_reg;
	logic                  first_pass_reg;
	state_type             state_reg;
	state_type             state_next;

	// Bus side
	logic [31:0]           prdata_reg;
	logic                  err_reg;
	logic                  setup;
	logic                  wr_commit;
	logic                  cmd_arm;
	logic                  cmd_bustrg;
	logic                  cmd_abort;

	// Events and outputs
	logic [SYNC_W-1:0]     rise;
	logic                  ext_evt;
	logic                  key_evt;
	logic                  tlink_evt;
	logic                  pace_evt;
	logic                  go;
	logic                  last_scan;
	logic                  scan_start_reg;
	logic                  chan_step_reg;
	logic                  arm_return_reg;
	logic [NUM_LINES-1:0]  tline_out_reg;

	scan_timer_if tmr_if ();

	scan_interval_timer #(
		.MS_CYCLES_P (MS_CYCLES_P)
	) u_timer (
		.i_clk    (I_CLK_SYS),
		.i_arst_n (I_ARST_N),
		.tmr      (tmr_if.timer)
	);

	scan_input_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.i_clk    (I_CLK_SYS),
		.i_arst_n (I_ARST_N),
		.i_async  ({I_TLINE_IN, I_STEP_KEY, I_EXT_TRIG}),
		.o_rise   (rise)
	);

	assign ext_evt   = rise[0];
	assign key_evt   = rise[1];
	assign tlink_evt = |(rise[SYNC_W-1:2] & line_onehot(in_line_reg));

	// APB decode
	assign setup      = I_PSEL && !I_PENABLE;
	assign wr_commit  = I_PSEL && I_PENABLE && I_PWRITE && !err_reg;
	assign cmd_arm    = wr_commit && (I_PADDR == ADDR_CMD) && I_PWDATA[CMD_ARM_BIT];
	assign cmd_bustrg = wr_commit && (I_PADDR == ADDR_CMD) && I_PWDATA[CMD_BUSTRG_BIT];
	assign cmd_abort  = wr_commit && (I_PADDR == ADDR_CMD) && I_PWDATA[CMD_ABORT_BIT];

	// Error and read data settle in the setup cycle, so the access needs no wait
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			err_reg <= 1'b0;
		end else if (setup) begin
			if (I_PWRITE) begin
				err_reg <= write_refused(I_PADDR, I_PWDATA);
			end else begin
				// Reads fail only on unmapped offsets; zero data would trip the line check
				err_reg <= !(I_PADDR == ADDR_STATUS || I_PADDR == ADDR_LINES) && write_refused(I_PADDR, 32'h00000000);
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			prdata_reg <= 32'h00000000;
		end else if (setup && !I_PWRITE) begin
			prdata_reg <= 32'h00000000;
			if (I_PADDR == ADDR_CTRL) begin
				prdata_reg[CTRL_SRC_LSB +: 3] <= source_reg;
				prdata_reg[CTRL_BYPASS_BIT]   <= bypass_reg;
			end else if (I_PADDR == ADDR_LINES) begin
				prdata_reg[LINES_IN_LSB +: LINE_W]  <= in_line_reg;
				prdata_reg[LINES_OUT_LSB +: LINE_W] <= out_line_reg;
			end else if (I_PADDR == ADDR_INTERVAL) begin
				prdata_reg[INTERVAL_W-1:0] <= interval_reg;
			end else if (I_PADDR == ADDR_COUNT) begin
				prdata_reg[COUNT_W-1:0] <= total_reg;
			end else if (I_PADDR == ADDR_STATUS) begin
				prdata_reg[STAT_STATE_LSB +: 2]        <= state_reg;
				prdata_reg[STAT_EXPIRED_BIT]           <= tmr_if.expired;
				prdata_reg[STAT_FIRST_BIT]             <= first_pass_reg;
				prdata_reg[STAT_COUNT_LSB +: COUNT_W]  <= done_cnt_reg;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			source_reg   <= RST_SOURCE;
			bypass_reg   <= RST_BYPASS;
			in_line_reg  <= RST_IN_LINE;
			out_line_reg <= RST_OUT_LINE;
			interval_reg <= RST_INTERVAL;
			total_reg    <= RST_COUNT;
		end else if (wr_commit) begin
			if (I_PADDR == ADDR_CTRL) begin
				source_reg <= source_type'(I_PWDATA[CTRL_SRC_LSB +: 3]);
				bypass_reg <= I_PWDATA[CTRL_BYPASS_BIT];
			end else if (I_PADDR == ADDR_LINES) begin
				in_line_reg  <= I_PWDATA[LINES_IN_LSB +: LINE_W];
				out_line_reg <= I_PWDATA[LINES_OUT_LSB +: LINE_W];
			end else if (I_PADDR == ADDR_INTERVAL) begin
				interval_reg <= I_PWDATA[INTERVAL_W-1:0];
			end else if (I_PADDR == ADDR_COUNT) begin
				total_reg <= I_PWDATA[COUNT_W-1:0];
			end
		end
	end

	// Pacing event per source; hold yields none until the source is rewritten
	always_comb begin
		pace_evt = 1'b0;
		case (source_reg)
			SRC_TIMER:    pace_evt = tmr_if.expired || key_evt;
			SRC_EXTERNAL: pace_evt = ext_evt || key_evt;
			SRC_BUS:      pace_evt = cmd_bustrg || key_evt;
			SRC_MANUAL:   pace_evt = key_evt;
			SRC_TLINK:    pace_evt = tlink_evt || key_evt;
			SRC_IMMED:    pace_evt = 1'b1;
			SRC_HOLD:     pace_evt = 1'b0;
			default:      pace_evt = 1'b0;
		endcase
		// Acceptor (bypass off) always waits for the event
		if (bypass_reg && first_pass_reg && (source_reg == SRC_EXTERNAL || source_reg == SRC_TLINK)) begin
			pace_evt = 1'b1;
		end
	end

	assign go        = (state_reg == ST_WAIT) && pace_evt && !cmd_abort;
	assign last_scan = (total_reg != '0) && (done_cnt_reg + 1'b1 == total_reg);

	// Sequencer; scan completion or an abort leaves the scan state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_arm) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cmd_abort) begin
					state_next = ST_IDLE;
				end else if (go) begin
					state_next = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (cmd_abort) begin
					state_next = ST_IDLE;
				end else if (I_SCAN_DONE) begin
					state_next = last_scan ? ST_RETURN : ST_WAIT;
				end
			end
			ST_RETURN: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Scan counter and first-pass flag
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			done_cnt_reg   <= '0;
			first_pass_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && cmd_arm) begin
			done_cnt_reg   <= '0;
			first_pass_reg <= 1'b1;
		end else begin
			if (go) begin
				first_pass_reg <= 1'b0;
			end
			if (state_reg == ST_SCAN && I_SCAN_DONE && !cmd_abort) begin
				done_cnt_reg <= done_cnt_reg + 1'b1;
			end
		end
	end

	// Timer measures from each scan start; also from arming, so the first scan waits one interval
	assign tmr_if.restart  = go || (state_reg == ST_IDLE && cmd_arm);
	assign tmr_if.interval = interval_reg;

	// Hand-over pulses and trigger-bus output pulse
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			scan_start_reg <= 1'b0;
			chan_step_reg  <= 1'b0;
			arm_return_reg <= 1'b0;
			tline_out_reg  <= '0;
		end else begin
			scan_start_reg <= go;
			chan_step_reg  <= (state_reg == ST_SCAN) && I_CHAN_EVENT;
			arm_return_reg <= (state_reg == ST_RETURN);
			tline_out_reg  <= (go && source_reg == SRC_TLINK) ? line_onehot(out_line_reg) : '0;
		end
	end

	assign O_PRDATA      = prdata_reg;
	assign O_PREADY      = 1'b1;
	assign O_PSLVERR     = I_PSEL && I_PENABLE && err_reg;
	assign O_SCAN_START  = scan_start_reg;
	assign O_CHAN_STEP   = chan_step_reg;
	assign O_ARM_RETURN  = arm_return_reg;
	assign O_SCAN_ACTIVE = (state_reg == ST_SCAN);
	assign O_TLINE_OUT   = tline_out_reg;
	assign O_TLINE_OE    = tline_out_reg;

endmodule

//--- logic/scan_seq_pkg.sv
// Purpose: Shared constants and types of the scan-layer trigger sequencer.
// Assumes: 25 MHz system clock, 32-bit APB register bus.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package scan_seq_pkg;

	// Clock and timer resolution
	localparam int CLK_PERIOD_NS    = 40;
	localparam int MS_PERIOD_NS     = 1_000_000;
	localparam int MS_CYCLES        = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Interval in milliseconds, 0 to 99999.999 s
	localparam int INTERVAL_W       = 27;
	localparam int INTERVAL_MAX_MS  = 99_999_999;

	// Scan repeat total, 0 means infinite
	localparam int COUNT_W          = 14;
	localparam int COUNT_MAX        = 9999;

	// Trigger bus lines, numbered 1 to 6
	localparam int NUM_LINES        = 6;
	localparam int LINE_W           = 3;

	// Register offsets
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_LINES    = 8'h04;
	localparam logic [7:0] ADDR_INTERVAL = 8'h08;
	localparam logic [7:0] ADDR_COUNT    = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_CMD      = 8'h14;

	// Field positions
	localparam int CTRL_SRC_LSB     = 0;
	localparam int CTRL_BYPASS_BIT  = 3;
	localparam int LINES_IN_LSB     = 0;
	localparam int LINES_OUT_LSB    = 8;
	localparam int CMD_ARM_BIT      = 0;
	localparam int CMD_BUSTRG_BIT   = 1;
	localparam int CMD_ABORT_BIT    = 2;
	localparam int STAT_STATE_LSB   = 0;
	localparam int STAT_EXPIRED_BIT = 2;
	localparam int STAT_FIRST_BIT   = 3;
	localparam int STAT_COUNT_LSB   = 16;

	// Pacing sources
	typedef enum logic [2:0] {
		SRC_TIMER    = 3'h0,
		SRC_EXTERNAL = 3'h1,
		SRC_BUS      = 3'h2,
		SRC_MANUAL   = 3'h3,
		SRC_TLINK    = 3'h4,
		SRC_IMMED    = 3'h5,
		SRC_HOLD     = 3'h6
	} source_type;

	// Sequencer states, Gray along idle, wait, scan, return
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WAIT   = 2'b01,
		ST_SCAN   = 2'b11,
		ST_RETURN = 2'b10
	} state_type;

	// Values after reset
	localparam source_type            RST_SOURCE   = SRC_IMMED;
	localparam logic                  RST_BYPASS   = 1'b0;
	localparam logic [LINE_W-1:0]     RST_IN_LINE  = 3'h1;
	localparam logic [LINE_W-1:0]     RST_OUT_LINE = 3'h2;
	localparam logic [INTERVAL_W-1:0] RST_INTERVAL = 27'h0000001;
	localparam logic [COUNT_W-1:0]    RST_COUNT    = 14'h0001;

endpackage

//--- logic/scan_timer_if.sv
// Purpose: Carries restart, interval and expiry between sequencer and timer.
// Assumes: Both ends on the system clock.
// Notes:   Expiry is a level that stays up until the next restart.
`timescale 1ns/1ns
interface scan_timer_if;
	import scan_seq_pkg::*;
	logic                  restart;
	logic [INTERVAL_W-1:0] interval;
	logic                  expired;
	modport ctrl  (output restart, output interval, input expired);
	modport timer (input restart, input interval, output expired);
endinterface

//--- logic/scan_interval_timer.sv
// Purpose: Millisecond interval timer measured from the last restart.
// Assumes: MS_CYCLES system clocks make one millisecond.
// Notes:   Elapsed time saturates, so a late scan still sees expiry.
`timescale 1ns/1ns
module scan_interval_timer
	import scan_seq_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Timer link
	scan_timer_if.timer tmr
);
	localparam int PRESC_W = $clog2(MS_CYCLES_P + 1);

	logic [PRESC_W-1:0]    presc_reg;
	logic [INTERVAL_W-1:0] elapsed_reg;

	if (MS_CYCLES_P < 1) begin : g_check
		$error("MS_CYCLES_P must be at least one");
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			presc_reg   <= '0;
			elapsed_reg <= '0;
		end else if (tmr.restart) begin
			presc_reg   <= '0;
			elapsed_reg <= '0;
		end else if (elapsed_reg != {INTERVAL_W{1'b1}}) begin
			if (presc_reg == PRESC_W'(MS_CYCLES_P - 1)) begin
				presc_reg   <= '0;
				elapsed_reg <= elapsed_reg + 1'b1;
			end else begin
				presc_reg <= presc_reg + 1'b1;
			end
		end
	end

	// Expiry holds until restart
	assign tmr.expired = (elapsed_reg >= tmr.interval);

endmodule

//--- logic/scan_input_sync.sv
// Purpose: Two-flop synchroniser with rising-edge pulse per bit.
// Assumes: Inputs are asynchronous pins, active high.
// Notes:   Only the second flop feeds the edge detector.
`timescale 1ns/1ns
module scan_input_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	// Pins and pulses
	input  wire logic [WIDTH-1:0] i_async,
	output wire logic [WIDTH-1:0] o_rise
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	if (WIDTH < 1) begin : g_check
		$error("WIDTH must be at least one");
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign o_rise = sync_reg & ~prev_reg;

endmodule

//--- test/scan_seq_monitor.sv
// Purpose: Port-level checks of the scan sequencer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Abort writes are left out where they may cut a scan short.
`timescale 1ns/1ns
module scan_seq_monitor
	import scan_seq_pkg::*;
(
	// Clock and reset
	input  wire logic                 I_CLK_SYS,
	input  wire logic                 I_ARST_N,
	// APB
	input  wire logic                 I_PSEL,
	input  wire logic                 I_PENABLE,
	input  wire logic                 I_PWRITE,
	input  wire logic [7:0]           I_PADDR,
	input  wire logic [31:0]          I_PWDATA,
	input  wire logic                 O_PSLVERR,
	// Triggers and channel layer
	input  wire logic [NUM_LINES-1:0] O_TLINE_OUT,
	input  wire logic [NUM_LINES-1:0] O_TLINE_OE,
	input  wire logic                 I_CHAN_EVENT,
	input  wire logic                 I_SCAN_DONE,
	input  wire logic                 O_SCAN_START,
	input  wire logic                 O_CHAN_STEP,
	input  wire logic                 O_SCAN_ACTIVE,
	input  wire logic                 O_ARM_RETURN
);
	logic wr_acc;
	logic abt;
	assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
	assign abt    = wr_acc && I_PADDR == ADDR_CMD && I_PWDATA[CMD_ABORT_BIT];
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_ARST_N);

	a_lines_same: assert property (wr_acc && I_PADDR == ADDR_LINES && I_PWDATA[2:0] == I_PWDATA[10:8] |-> O_PSLVERR)
		else $error("equal trigger lines accepted");
	a_count_max: assert property (wr_acc && I_PADDR == ADDR_COUNT && I_PWDATA > COUNT_MAX |-> O_PSLVERR)
		else $error("repeat total above range accepted");
	a_interval_max: assert property (wr_acc && I_PADDR == ADDR_INTERVAL && I_PWDATA > INTERVAL_MAX_MS |-> O_PSLVERR)
		else $error("interval above range accepted");
	a_start_single: assert property (O_SCAN_START |=> !O_SCAN_START)
		else $error("scan start longer than one cycle");
	a_active_rise: assert property ($rose(O_SCAN_ACTIVE) |-> O_SCAN_START)
		else $error("scan active without start");
	a_scan_held: assert property (O_SCAN_ACTIVE && !I_SCAN_DONE && !abt |=> O_SCAN_ACTIVE && !O_SCAN_START)
		else $error("scan cut short or restarted");
	a_done_ends: assert property (O_SCAN_ACTIVE && I_SCAN_DONE && !abt |=> !O_SCAN_ACTIVE)
		else $error("scan done not taken");
	a_step_follow: assert property (I_CHAN_EVENT && O_SCAN_ACTIVE |=> O_CHAN_STEP)
		else $error("channel event lost");
	a_step_cause: assert property (O_CHAN_STEP |-> $past(I_CHAN_EVENT))
		else $error("channel step without event");
	a_arm_return: assert property (O_ARM_RETURN |-> $past(I_SCAN_DONE, 2) && !O_SCAN_ACTIVE)
		else $error("arm return without scan end");
	a_tline_pulse: assert property (|O_TLINE_OUT |-> O_SCAN_START && O_TLINE_OE == O_TLINE_OUT && $onehot(O_TLINE_OUT))
		else $error("bad trigger line output");

	c_arm_return: cover property (O_ARM_RETURN);
	c_tline_out: cover property (|O_TLINE_OUT);
	c_chan_step: cover property (I_CHAN_EVENT && O_SCAN_ACTIVE);
endmodule

bind scan_layer_trigger_sequencer scan_seq_monitor i_scan_seq_monitor (
	.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PSLVERR(O_PSLVERR),
	.O_TLINE_OUT(O_TLINE_OUT), .O_TLINE_OE(O_TLINE_OE), .I_CHAN_EVENT(I_CHAN_EVENT),
	.I_SCAN_DONE(I_SCAN_DONE), .O_SCAN_START(O_SCAN_START), .O_CHAN_STEP(O_CHAN_STEP),
	.O_SCAN_ACTIVE(O_SCAN_ACTIVE), .O_ARM_RETURN(O_ARM_RETURN));

//--- test/scan_channel_model.sv
// Purpose: Behavioural channel layer below the scan sequencer.
// Assumes: Same clock; scan length of at least 2 cycles.
// Notes:   Done is sent only while a scan is active, so an abort leaves nothing pending.
`timescale 1ns/1ns
module scan_channel_model (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	// Sequencer side
	input  wire logic       i_start,
	input  wire logic       i_active,
	input  wire logic [7:0] i_dly,
	output logic            o_chan_event,
	output logic            o_scan_done
);
	logic [7:0] cnt_reg;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg      <= 8'h00;
			o_chan_event <= 1'h0;
			o_scan_done  <= 1'h0;
		end else begin
			o_chan_event <= i_active && cnt_reg == 8'h02;
			o_scan_done  <= i_active && cnt_reg == 8'h01;
			if (i_start)
				cnt_reg <= i_dly;
			else if (cnt_reg != 8'h00)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule

//--- test/tb.sv
// Purpose: Self-checking bench of the scan sequencer over APB and trigger pins.
// Assumes: Millisecond shortened to MS cycles.
// Notes:   Every task starts and ends just after a rising edge.
`timescale 1ns/1ns
module tb
	import scan_seq_pkg::*;
;
	localparam int MS = 4;
	logic        clk, rst_n, psel, pen, pwr, ext, key;
	logic        pready, perr, ev, done, start, step, active, ret;
	logic [7:0]  paddr, dly;
	logic [31:0] pwdata, prdata;
	logic [5:0]  tin, tout, toe, tl;
	int          err_total, checks, cyc, rets;

	scan_layer_trigger_sequencer #(.MS_CYCLES_P(MS)) i_scan_layer_trigger_sequencer (
		.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
		.I_EXT_TRIG(ext), .I_STEP_KEY(key), .I_TLINE_IN(tin), .O_TLINE_OUT(tout), .O_TLINE_OE(toe),
		.I_CHAN_EVENT(ev), .I_SCAN_DONE(done), .O_SCAN_START(start), .O_CHAN_STEP(step),
		.O_SCAN_ACTIVE(active), .O_ARM_RETURN(ret));
	scan_channel_model i_scan_channel_model (.i_clk(clk), .i_arst_n(rst_n), .i_start(start),
		.i_active(active), .i_dly(dly), .o_chan_event(ev), .o_scan_done(done));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ret === 1'h1)
			rets <= rets + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	task summarize();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee, input logic [31:0] eq);
		int n;
		n = 0;
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		chk(pready, 1'h1);
		chk(perr, ee);
		if (!w)
			chk(prdata, eq);
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask

	task w(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'h1, a, d, e, 32'h0);
	endtask

	// Arrival is counted in edges since the call
	task ws(input int lo, input int hi, input logic want);
		int n;
		logic s;
		s = 1'h0;
		for (n = 0; n < hi && !s; n++) begin
			@(posedge clk);
			s = start === 1'h1;
		end
		tl = tout;
		chk(s, want);
		if (want)
			chk(n >= lo, 1'h1);
	endtask

	// Pins stay high until the answer, since only a rising edge counts
	task trig(input int k, input logic want);
		if (k == 0)
			ext <= 1'h1;
		else if (k == 1)
			key <= 1'h1;
		else
			tin[k-2] <= 1'h1;
		ws(0, 8, want);
		ext <= 1'h0;
		key <= 1'h0;
		tin <= 6'h00;
		// One low edge, so a following press is seen as a new edge
		@(posedge clk);
	endtask

	task go(input logic [3:0] c, input logic [13:0] n);
		w(ADDR_CMD, 32'h4, 1'h0);
		w(ADDR_CTRL, {28'h0, c}, 1'h0);
		w(ADDR_COUNT, {18'h0, n}, 1'h0);
		w(ADDR_CMD, 32'h1, 1'h0);
	endtask

	initial begin
		psel = 1'h0;
		pen = 1'h0;
		pwr = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext = 1'h0;
		key = 1'h0;
		tin = 6'h00;
		dly = 8'h02;
		err_total = 0;
		checks = 0;
		cyc = 0;
		rets = 0;
		rst_n = 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		apb(1'h0, ADDR_CTRL, 32'h0, 1'h0, 32'h5);
		apb(1'h0, ADDR_LINES, 32'h0, 1'h0, 32'h201);
		apb(1'h0, ADDR_INTERVAL, 32'h0, 1'h0, 32'h1);
		apb(1'h0, ADDR_COUNT, 32'h0, 1'h0, 32'h1);
		w(ADDR_LINES, 32'h303, 1'h1);
		w(ADDR_LINES, 32'h107, 1'h1);
		w(ADDR_LINES, 32'h402, 1'h0);
		w(ADDR_COUNT, 32'h2710, 1'h1);
		w(ADDR_COUNT, 32'h270F, 1'h0);
		w(ADDR_INTERVAL, 32'h5F5E100, 1'h1);
		w(ADDR_INTERVAL, 32'h5F5E0FF, 1'h0);
		w(ADDR_STATUS, 32'h0, 1'h1);
		w(8'h18, 32'h0, 1'h1);
		apb(1'h0, ADDR_INTERVAL, 32'h0, 1'h0, 32'h5F5E0FF);
		go(4'h5, 14'h3);
		repeat (3) ws(0, 12, 1'h1);
		ws(0, 30, 1'h0);
		chk(rets, 32'h1);
		apb(1'h0, ADDR_STATUS, 32'h0, 1'h0, 32'h30000);
		go(4'h5, 14'h0);
		repeat (6) ws(0, 12, 1'h1);
		chk(rets, 32'h1);
		go(4'h6, 14'h1);
		ws(0, 40, 1'h0);
		w(ADDR_CTRL, 32'h5, 1'h0);
		ws(0, 8, 1'h1);
		go(4'h1, 14'h2);
		ws(0, 20, 1'h0);
		trig(0, 1'h1);
		ws(0, 10, 1'h0);
		trig(1, 1'h1);
		ws(0, 8, 1'h0);
		chk(rets, 32'h2);
		trig(1, 1'h0);
		go(4'h9, 14'h1);
		ws(0, 8, 1'h1);
		go(4'hC, 14'h1);
		ws(0, 8, 1'h1);
		chk(tl, 32'h8);
		go(4'hB, 14'h1);
		ws(0, 20, 1'h0);
		trig(1, 1'h1);
		go(4'h4, 14'h1);
		trig(2, 1'h0);
		trig(3, 1'h1);
		chk(tl, 32'h8);
		go(4'h2, 14'h1);
		ws(0, 20, 1'h0);
		w(ADDR_CMD, 32'h2, 1'h0);
		chk(start, 1'h1);
		ws(0, 8, 1'h0);
		w(ADDR_INTERVAL, 32'h2, 1'h0);
		go(4'h0, 14'h2);
		ws(2*MS-2, 2*MS+6, 1'h1);
		ws(2*MS-2, 2*MS+6, 1'h1);
		w(ADDR_INTERVAL, 32'h1, 1'h0);
		dly <= 8'h1E;
		go(4'h0, 14'h2);
		ws(0, 2*MS+6, 1'h1);
		ws(28, 40, 1'h1);
		summarize();
	end
endmodule
